// file: logic/bmad_map.vh
// Address map and reset constants for the boot memory address decoder
`ifndef BMAD_MAP_VH
`define BMAD_MAP_VH
`define BMAD_BOOT_BASE 32'h00000000
`define BMAD_BOOT_LAST 32'h000FFFFF
`define BMAD_SRAMA_BASE 32'h00100000
`define BMAD_SRAMB_BASE 32'h00200000
`define BMAD_SRAMC_BASE 32'h00300000
`define BMAD_FSRAM_BASE 32'h00500000
`define BMAD_REGION_MASK 32'hFFF00000
`define BMAD_CS_MSB 31
`define BMAD_CS_LSB 28
`define BMAD_CS_FIRST 4'h1
`define BMAD_PORT0_CS_LAST 4'h6
`define BMAD_PORT1_CS_FIRST 4'h7
`define BMAD_CS_LAST 4'h9
`define BMAD_SYSC_BASE 32'hFFFFC000
`define BMAD_PERIPH_BASE 32'hFFFA0000
`define BMAD_PERIPH_LAST 32'hFFFCFFFF
`define BMAD_SWAP_RST 1'b0
`define BMAD_CAPTURE_HOLD 3'h4
`define BMAD_STATIC_BYTE_SEL 1'b1
`define BMAD_STATIC_WIDTH16 2'h1
`define BMAD_STATIC_STROBE_CS 1'b1
`define BMAD_TGT_NONE 4'h0
`define BMAD_TGT_ROM 4'h1
`define BMAD_TGT_CS0 4'h2
`define BMAD_TGT_SRAMC 4'h3
`define BMAD_TGT_SRAMA 4'h4
`define BMAD_TGT_SRAMB 4'h5
`define BMAD_TGT_FSRAM 4'h6
`define BMAD_TGT_EBI 4'h7
`define BMAD_TGT_PERIPH 4'h8
`define BMAD_TGT_SYSC 4'h9
`endif

// file: logic/bmad_sync.v
// Three-stage synchroniser with agreement filter for a pin level
`timescale 1ns/1ps
module bmad_sync (
    clk,
    pin_in,
    level_out
);
input wire clk;
input wire pin_in;
output wire level_out;
reg meta_ff;
reg s2_ff;
reg s3_ff;
reg level_ff;
// No reset: stages must keep tracking the pin while reset is held
always @(posedge clk) begin
    meta_ff <= pin_in;
    s2_ff <= meta_ff;
    s3_ff <= s2_ff;
    // Change counts only once stages two and three agree
    if (s2_ff == s3_ff) begin
        level_ff <= s3_ff;
    end
end
assign level_out = level_ff;
endmodule // bmad_sync

// file: logic/bmad_region.v
// Fixed-region decode for memories the boot layout never moves
`timescale 1ns/1ps
`include "bmad_map.vh"
module bmad_region (
    addr,
    tgt,
    cs_index
);
input wire [31:0] addr;
output reg [3:0] tgt;
output reg [3:0] cs_index;
function in_mb;
    input [31:0] a;
    input [31:0] base;
    begin
        in_mb = ((a & `BMAD_REGION_MASK) == base);
    end
endfunction
always @* begin
    tgt = `BMAD_TGT_NONE;
    cs_index = 4'h0;
    if (addr >= `BMAD_SYSC_BASE) begin
        tgt = `BMAD_TGT_SYSC;
    end else if (addr >= `BMAD_PERIPH_BASE && addr <= `BMAD_PERIPH_LAST) begin
        tgt = `BMAD_TGT_PERIPH;
    end else if (addr[`BMAD_CS_MSB:`BMAD_CS_LSB] >= `BMAD_CS_FIRST &&
                 addr[`BMAD_CS_MSB:`BMAD_CS_LSB] <= `BMAD_CS_LAST) begin
        // One chip select per 256 Mbyte region
        tgt = `BMAD_TGT_EBI;
        cs_index = addr[`BMAD_CS_MSB:`BMAD_CS_LSB] - `BMAD_CS_FIRST;
    end else if (in_mb(addr, `BMAD_SRAMA_BASE)) begin
        tgt = `BMAD_TGT_SRAMA;
    end else if (in_mb(addr, `BMAD_SRAMB_BASE)) begin
        tgt = `BMAD_TGT_SRAMB;
    end else if (in_mb(addr, `BMAD_SRAMC_BASE)) begin
        tgt = `BMAD_TGT_SRAMC;
    end else if (in_mb(addr, `BMAD_FSRAM_BASE)) begin
        tgt = `BMAD_TGT_FSRAM;
    end
end
endmodule // bmad_region

// file: logic/bmad_top.v
// Boot memory address decoder: boot window selection and region decode
`timescale 1ns/1ps
`include "bmad_map.vh"
// Overview of operation
// - First fetch after reset goes to address zero; boot memory mapped there.
// - Swap bit set: internal SRAM at zero for processor masters, boot-select pin ignored for them.
// - Swap bit clear: captured boot select picks ROM or external memory.
// - Boot-select level captured during reset, governs selection afterwards.
// - Window zero to 0x000FFFFF decodes to selected boot memory.
// - Captured level one routes boot window to embedded ROM.
// - Captured level zero routes boot window to first chip select.
// - Unaffected memories stay at fixed bases in every configuration.
// - External boot: static controller defaults byte select, 16-bit, CS strobes.
// - Each external chip select decodes its own 256 Mbyte region.
// - System controller decoded in top 16 Kbytes of address space.
// - After swap SRAM at zero for processor masters, also at normal base.
module bmad_top (
    clk,
    reset,
    boot_select_pin,
    swap_set,
    swap_clear,
    req_valid,
    req_addr,
    req_cpu,
    dec_valid,
    dec_target,
    dec_offset,
    dec_cs_index,
    first_chip_select_n,
    swap_state,
    boot_from_rom,
    static_mem_ctrl_byte_sel,
    static_mem_ctrl_width,
    static_mem_ctrl_strobe_cs,
    reset_vector
);
input wire clk;
input wire reset;
input wire boot_select_pin;
input wire swap_set;
input wire swap_clear;
input wire req_valid;
input wire [31:0] req_addr;
input wire req_cpu;
output wire dec_valid;
output reg [3:0] dec_target;
output reg [31:0] dec_offset;
output reg [3:0] dec_cs_index;
output reg first_chip_select_n;
output wire swap_state;
output wire boot_from_rom;
output reg static_mem_ctrl_byte_sel;
output reg [1:0] static_mem_ctrl_width;
output reg static_mem_ctrl_strobe_cs;
output wire [31:0] reset_vector;

// ----------------------------------------
// Boot select capture
// ----------------------------------------
wire pin_level;
reg [2:0] hold_cnt_ff;
reg boot_rom_ff;
reg swap_ff;
reg valid_ff;
bmad_sync u_sync (
    .clk(clk),
    .pin_in(boot_select_pin),
    .level_out(pin_level)
);
// Latch follows the pin during reset and a short window after it.
// Window outlasts the synchroniser, so a two-cycle reset still samples cleanly.
always @(posedge clk) begin
    if (reset) begin
        hold_cnt_ff <= `BMAD_CAPTURE_HOLD;
    end else if (hold_cnt_ff != 3'h0) begin
        hold_cnt_ff <= hold_cnt_ff - 3'h1;
    end
end
always @(posedge clk) begin
    if (reset || hold_cnt_ff != 3'h0) begin
        boot_rom_ff <= pin_level;
    end
end
assign boot_from_rom = boot_rom_ff;

// ----------------------------------------
// Swap bit
// ----------------------------------------
// Only a software write sets it; nothing internal does
always @(posedge clk) begin
    if (reset) begin
        swap_ff <= `BMAD_SWAP_RST;
    end else if (swap_set) begin
        swap_ff <= 1'b1;
    end else if (swap_clear) begin
        swap_ff <= 1'b0;
    end
end
assign swap_state = swap_ff;
assign reset_vector = `BMAD_BOOT_BASE;

// ----------------------------------------
// Decode
// ----------------------------------------
wire [3:0] fixed_tgt;
wire [3:0] fixed_cs;
wire in_boot;
reg [3:0] nxt_target;
reg [31:0] nxt_offset;
reg [3:0] nxt_cs;
bmad_region u_region (
    .addr(req_addr),
    .tgt(fixed_tgt),
    .cs_index(fixed_cs)
);
assign in_boot = (req_addr <= `BMAD_BOOT_LAST);
always @* begin
    nxt_target = fixed_tgt;
    nxt_offset = req_addr;
    nxt_cs = fixed_cs;
    if (in_boot) begin
        nxt_offset = req_addr - `BMAD_BOOT_BASE;
        if (swap_ff && req_cpu) begin
            nxt_target = `BMAD_TGT_SRAMC;
        end else if (boot_rom_ff) begin
            nxt_target = `BMAD_TGT_ROM;
        end else begin
            nxt_target = `BMAD_TGT_CS0;
            nxt_cs = 4'h0;
        end
    end else if (fixed_tgt == `BMAD_TGT_SRAMC) begin
        nxt_offset = req_addr - `BMAD_SRAMC_BASE;
    end
end
// Registered outputs trade one cycle of latency for clean timing
always @(posedge clk) begin
    if (reset) begin
        valid_ff <= 1'b0;
        dec_target <= `BMAD_TGT_NONE;
        dec_offset <= 32'h00000000;
        dec_cs_index <= 4'h0;
        first_chip_select_n <= 1'b1;
    end else begin
        valid_ff <= req_valid;
        dec_target <= req_valid ? nxt_target : `BMAD_TGT_NONE;
        dec_offset <= nxt_offset;
        dec_cs_index <= nxt_cs;
        first_chip_select_n <= ~(req_valid &&
            (nxt_target == `BMAD_TGT_CS0 ||
             (nxt_target == `BMAD_TGT_EBI && nxt_cs == 4'h0)));
    end
end
assign dec_valid = valid_ff;

// ----------------------------------------
// Static controller boot defaults
// ----------------------------------------
always @(posedge clk) begin
    if (reset) begin
        static_mem_ctrl_byte_sel <= `BMAD_STATIC_BYTE_SEL;
        static_mem_ctrl_width <= `BMAD_STATIC_WIDTH16;
        static_mem_ctrl_strobe_cs <= `BMAD_STATIC_STROBE_CS;
    end
end
endmodule // bmad_top

// file: bench/bmad_checker.sv
// Assertion checker for the boot memory address decoder
`timescale 1ns/1ps
module bmad_checker (
    input logic clk,
    input logic reset,
    input logic swap_set,
    input logic swap_clear,
    input logic req_valid,
    input logic [31:0] req_addr,
    input logic req_cpu,
    input logic [3:0] dec_target,
    input logic [3:0] dec_cs_index,
    input logic first_chip_select_n,
    input logic swap_state,
    input logic boot_from_rom
);
default clocking @(posedge clk); endclocking
default disable iff (reset);
wire lo = req_valid && req_addr < 32'h00100000;
// Swap edge itself excluded: which map it sees is left open
wire bt = lo && !swap_set && (!swap_state || !req_cpu);
property p_rom; bt && boot_from_rom |=> dec_target == 4'h1; endproperty
a_rom: assert property (p_rom) else $error("boot window not on rom");
property p_cs0;
    bt && !boot_from_rom |=> dec_target == 4'h2 && !first_chip_select_n && dec_cs_index == 4'h0;
endproperty
a_cs0: assert property (p_cs0) else $error("boot window not on cs0");
property p_swp; lo && swap_state && req_cpu && !swap_clear |=> dec_target == 4'h3; endproperty
a_swp: assert property (p_swp) else $error("swapped sram not at zero");
property p_rst; $fell(reset) |-> !swap_state; endproperty
a_rst: assert property (p_rst) else $error("swap survived reset");
// Capture window closes four edges after release
property p_frz; !reset [*5] |=> $stable(boot_from_rom); endproperty
a_frz: assert property (p_frz) else $error("boot level moved after reset");
property p_sys; req_valid && req_addr >= 32'hFFFFC000 |=> dec_target == 4'h9; endproperty
a_sys: assert property (p_sys) else $error("system area missed");
property p_ebi;
    req_valid && req_addr[31:28] == 4'h3 |=> dec_target == 4'h7 && dec_cs_index == 4'h2;
endproperty
a_ebi: assert property (p_ebi) else $error("chip select region missed");
property p_fix; req_valid && req_addr[31:20] == 12'h005 |=> dec_target == 4'h6; endproperty
a_fix: assert property (p_fix) else $error("fixed sram moved");
c_rom: cover property (bt && boot_from_rom);
c_cs0: cover property (bt && !boot_from_rom);
c_swp: cover property (swap_set ##1 swap_state);
endmodule // bmad_checker
bind bmad_top bmad_checker u_bmad_checker (.clk, .reset, .swap_set, .swap_clear,
    .req_valid, .req_addr, .req_cpu, .dec_target, .dec_cs_index, .first_chip_select_n,
    .swap_state, .boot_from_rom);

// file: bench/bmad_master.sv
// Bus master model issuing decode requests
`timescale 1ns/1ps
module bmad_master (
    input logic clk,
    input logic go,
    input logic [31:0] addr,
    input logic cpu,
    output logic req_valid = 1'b0,
    output logic [31:0] req_addr = 32'h00000000,
    output logic req_cpu = 1'b0
);
// Idle lines toggle so a stale address never looks valid
always @(posedge clk) begin
    req_valid <= go;
    req_addr <= go ? addr : ~req_addr;
    req_cpu <= go ? cpu : ~req_cpu;
end
endmodule // bmad_master

// file: bench/bmad_top_test.sv
// Self-checking bench for the boot memory address decoder
`timescale 1ns/1ps
module bmad_top_test;
logic clk = 1'b0;
logic reset = 1'b1;
logic boot_select_pin = 1'b1;
logic swap_set = 1'b0;
logic swap_clear = 1'b0;
logic go = 1'b0;
logic cpu = 1'b1;
logic [31:0] addr = 32'h00000000;
wire req_valid, req_cpu, dec_valid, first_chip_select_n, swap_state, boot_from_rom;
wire static_mem_ctrl_byte_sel, static_mem_ctrl_strobe_cs;
wire [1:0] static_mem_ctrl_width;
wire [3:0] dec_target, dec_cs_index;
wire [31:0] req_addr, dec_offset, reset_vector;
int failures = 0;
int tests_run = 0;
int cycles = 0;
// Row: address, processor master, expected target, expected chip select index
logic [40:0] rows [0:13] = '{
    {32'h00000010, 1'b1, 4'h1, 4'h0}, {32'h000FFFFF, 1'b0, 4'h1, 4'h0},
    {32'h00100000, 1'b1, 4'h4, 4'h0}, {32'h00200000, 1'b1, 4'h5, 4'h0},
    {32'h00300000, 1'b1, 4'h3, 4'h0}, {32'h00500000, 1'b1, 4'h6, 4'h0},
    {32'h00400000, 1'b1, 4'h0, 4'h0}, {32'h10000000, 1'b1, 4'h7, 4'h0},
    {32'h30000000, 1'b1, 4'h7, 4'h2}, {32'h9FFFFFFF, 1'b1, 4'h7, 4'h8},
    {32'hFFFA0000, 1'b1, 4'h8, 4'h0}, {32'hFFFFC000, 1'b1, 4'h9, 4'h0},
    {32'hFFFFFFFF, 1'b1, 4'h9, 4'h0}, {32'hA0000000, 1'b1, 4'h0, 4'h0}};
bmad_master u_bmad_master (.clk, .go, .addr, .cpu, .req_valid, .req_addr, .req_cpu);
bmad_top u_bmad_top (.clk, .reset, .boot_select_pin, .swap_set, .swap_clear, .req_valid,
    .req_addr, .req_cpu, .dec_valid, .dec_target, .dec_offset, .dec_cs_index,
    .first_chip_select_n, .swap_state, .boot_from_rom, .static_mem_ctrl_byte_sel,
    .static_mem_ctrl_width, .static_mem_ctrl_strobe_cs, .reset_vector);
task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
        failures++;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask
task wrap_up;
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
        $display("[ PASS ]");
    else
        $display("[ FAIL ]");
    $finish;
endtask
// Two cycles of reset, then wait out the pin capture window
task do_reset;
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    repeat (5) @(negedge clk);
endtask
task req(input logic [31:0] a, input logic c, input logic [3:0] exp);
    go = 1'b1;
    addr = a;
    cpu = c;
    @(negedge clk) go = 1'b0;
    @(negedge clk);
    chk(dec_valid, 1'b1);
    chk(dec_target, exp);
endtask
task pulse(input logic s);
    swap_set = s;
    swap_clear = !s;
    @(negedge clk) swap_set = 1'b0;
    swap_clear = 1'b0;
endtask
// One fixed rate; boot-time clock switching is left to software
initial begin
    forever #5 clk = ~clk;
end
always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
        failures++;
        wrap_up;
    end
end
initial begin
    do_reset;
    chk(boot_from_rom, 1'b1);
    chk(reset_vector, 32'h00000000);
    for (int i = 0; i < 14; i++) begin
        req(rows[i][40:9], rows[i][8], rows[i][7:4]);
        chk(dec_cs_index, rows[i][3:0]);
    end
    req(32'h00000010, 1'b1, 4'h1);
    chk(dec_offset, 32'h00000010);
    boot_select_pin = 1'b0;
    repeat (6) @(negedge clk);
    req(32'h00000000, 1'b1, 4'h1);
    pulse(1'b1);
    chk(swap_state, 1'b1);
    req(32'h00000000, 1'b1, 4'h3);
    req(32'h00000000, 1'b0, 4'h1);
    req(32'h00300000, 1'b1, 4'h3);
    do_reset;
    chk(swap_state, 1'b0);
    chk(boot_from_rom, 1'b0);
    req(32'h00000000, 1'b1, 4'h2);
    chk(first_chip_select_n, 1'b0);
    chk(static_mem_ctrl_width, 2'h1);
    chk(static_mem_ctrl_byte_sel, 1'b1);
    chk(static_mem_ctrl_strobe_cs, 1'b1);
    pulse(1'b1);
    req(32'h00000000, 1'b1, 4'h3);
    pulse(1'b0);
    req(32'h00000000, 1'b1, 4'h2);
    wrap_up;
end
endmodule // bmad_top_test
